// file: rtl/tsup_top.sv
`timescale 1ns/1ns
// Contract
// - counter advances on each cycle of the separate 128 kHz oscillator
// - reaching the selected limit is a time-out: interrupt or reset
// - restart instruction restarts the counter so no time-out occurs; a restart in the time-out tick cycle still lets it fire
// - periods from about 16 ms to about 8 s via period select
// - an interrupt-mode time-out may wake the device from sleep
// - mode from always-on fuse, reset enable and interrupt enable
// - always-on fuse forces reset mode, reset enable 1, irq enable 0
// - clearing reset enable or changing period needs the unlock sequence
// - an accidental enable still resets and stays enabled afterwards
// - control byte layout: flag7 ie6 p3 5 unlock4 wde3 p2..0
// - time-out in interrupt configuration sets the interrupt flag
// - flag cleared by vector execution or by writing one
// - interrupt requested only with flag, enable and global enable
// - combined mode: vector clears enable and flag, reset mode left
// - combined mode: unserviced flag at next time-out gives reset
// - change unlock clears itself four cycles after being written
// - reset-cause watchdog flag forces reset enable to one
// - period codes 0..9 give 2048 doubling to 1048576 cycles
module tsup_top
  import tsup_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [TSUP_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic osc_128k_in,
  input wire logic always_on_fuse_in,
  input wire logic restart_in,
  input wire logic irq_ack_in,
  input wire logic global_irq_en_in,
  input wire logic timeout_reset_flag_in,
  output logic irq_req_out,
  output logic wake_out,
  output logic reset_req_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic osc_s;
  logic fuse_s;
  logic osc_prev_q;
  logic osc_tick;
  logic [TSUP_CNT_W-1:0] cnt_q;
  logic [TSUP_CNT_W-1:0] limit;
  logic [2:0] unlock_cnt_q;
  logic unlocked;
  logic flag_q;
  logic ie_q;
  logic wde_q;
  logic [3:0] per_q;
  logic eff_wde;
  logic eff_ie;
  tsup_mode_e mode;
  logic timeout;
  logic irq_set;
  logic flag_clr;
  logic rst_fire;
  logic reset_req_q;
  logic irq_req_q;
  logic wake_q;
  logic unlock_start;
  logic change_ok;
  tsup_wr_s wr;
  tsup_ctrl_s ctrl_rd;

  // ----------------------------------------------------------------
  // bus slave and synchronisers
  // ----------------------------------------------------------------
  tsup_apb u_apb (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .ctrl_rd_in(ctrl_rd),
    .count_rd_in(cnt_q),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .wr_out(wr)
  );

  // oscillator and fuse come from outside this clock's domain
  tsup_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in({osc_128k_in, always_on_fuse_in}),
    .sync_out({osc_s, fuse_s})
  );

  // ----------------------------------------------------------------
  // oscillator tick
  // ----------------------------------------------------------------
  // the oscillator is far slower than clk_in, so a rising edge of
  // the synchronised level is one tick; no edge can be missed
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end

  assign osc_tick = osc_s & ~osc_prev_q;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign eff_wde = fuse_s | timeout_reset_flag_in | wde_q;
  assign eff_ie = ie_q & ~fuse_s;
  assign mode = tsup_mode(fuse_s, eff_wde, eff_ie);
  assign limit = tsup_limit(per_q);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // compare with >= so a shorter period chosen mid-count times out
  // on the next tick instead of wrapping past it
  assign timeout = osc_tick && (mode != TSUP_STOPPED)
    && (cnt_q >= limit - 21'h000001);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else if (restart_in || mode == TSUP_STOPPED) begin
      cnt_q <= '0;
    end else if (timeout) begin
      cnt_q <= '0;
    end else if (osc_tick) begin
      cnt_q <= cnt_q + 21'h000001;
    end
  end

  // ----------------------------------------------------------------
  // time-out actions
  // ----------------------------------------------------------------
  assign irq_set = timeout && (mode == TSUP_IRQ
    || (mode == TSUP_IRQ_RESET && !flag_q));
  assign rst_fire = timeout && (mode == TSUP_RESET
    || (mode == TSUP_IRQ_RESET && flag_q));

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= rst_fire;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flag
  // ----------------------------------------------------------------
  assign flag_clr = irq_ack_in | (wr.wr & wr.data.irq_flag);

  // a time-out in the clearing cycle keeps the flag set unless it requests reset
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      flag_q <= TSUP_CTRL_RST[TSUP_BIT_FLAG];
    end else begin
      flag_q <= irq_set | (flag_q & ~flag_clr);
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable
  // ----------------------------------------------------------------
  // a software write in the ack cycle wins: it is the re-arm
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ie_q <= TSUP_CTRL_RST[TSUP_BIT_IE];
    end else if (wr.wr) begin
      ie_q <= wr.data.irq_en;
    end else if (irq_ack_in && eff_wde) begin
      ie_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // timed unlock
  // ----------------------------------------------------------------
  assign unlocked = (unlock_cnt_q != 3'h0);
  assign unlock_start = wr.wr & wr.data.change_unlock
    & wr.data.reset_enable;
  assign change_ok = wr.wr & unlocked & ~wr.data.change_unlock;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      unlock_cnt_q <= 3'h0;
    end else if (unlock_start) begin
      unlock_cnt_q <= TSUP_UNLOCK_CYCLES;
    end else if (change_ok) begin
      unlock_cnt_q <= 3'h0;
    end else if (unlocked) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // reset enable and period select
  // ----------------------------------------------------------------
  // setting reset enable is always allowed; clearing needs unlock
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wde_q <= TSUP_WDE_RST;
    end else if (change_ok) begin
      wde_q <= wr.data.reset_enable;
    end else if (wr.wr && wr.data.reset_enable) begin
      wde_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      per_q <= TSUP_PER_RST;
    end else if (change_ok) begin
      per_q <= {wr.data.period_hi, wr.data.period_lo};
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_rd.irq_flag = flag_q;
    ctrl_rd.irq_en = eff_ie;
    ctrl_rd.period_hi = per_q[3];
    ctrl_rd.change_unlock = unlocked;
    ctrl_rd.reset_enable = eff_wde;
    ctrl_rd.period_lo = per_q[2:0];
  end

  // ----------------------------------------------------------------
  // interrupt request and wake-up
  // ----------------------------------------------------------------
  // wake ignores the global enable: a sleeping core must still rise
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_req_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_req_q <= flag_q & eff_ie & global_irq_en_in & ~flag_clr;
      wake_q <= flag_q & eff_ie & ~flag_clr;
    end
  end

  assign irq_req_out = irq_req_q;
  assign wake_out = wake_q;
  assign reset_req_out = reset_req_q;

endmodule

// file: inc/tsup_pkg.sv
package tsup_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int TSUP_CNT_W = 21;
  localparam int TSUP_ADDR_W = 12;
  localparam int TSUP_OSC_HZ = 128000;
  localparam logic [TSUP_CNT_W-1:0] TSUP_BASE_CYCLES = 21'h000800;
  localparam logic [3:0] TSUP_PER_MAX = 4'h9;
  localparam logic [2:0] TSUP_UNLOCK_CYCLES = 3'h4;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [TSUP_ADDR_W-1:0] TSUP_ADDR_CTRL = 12'h000;
  localparam logic [TSUP_ADDR_W-1:0] TSUP_ADDR_COUNT = 12'h004;
  localparam logic [7:0] TSUP_CTRL_RST = 8'h00;
  localparam logic [3:0] TSUP_PER_RST = 4'h0;
  localparam logic TSUP_WDE_RST = 1'b0;

  // field positions inside the control/status byte
  localparam int TSUP_BIT_FLAG = 7;
  localparam int TSUP_BIT_IE = 6;
  localparam int TSUP_BIT_PER3 = 5;
  localparam int TSUP_BIT_UNLOCK = 4;
  localparam int TSUP_BIT_WDE = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic period_hi;
    logic change_unlock;
    logic reset_enable;
    logic [2:0] period_lo;
  } tsup_ctrl_s;

  typedef struct packed {
    logic wr;
    tsup_ctrl_s data;
  } tsup_wr_s;

  typedef enum {
    TSUP_STOPPED,
    TSUP_IRQ,
    TSUP_RESET,
    TSUP_IRQ_RESET
  } tsup_mode_e;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // reserved codes above nine fall back to the longest period
  function automatic logic [TSUP_CNT_W-1:0] tsup_limit(
    input logic [3:0] code
  );
    logic [3:0] c;
    c = (code > TSUP_PER_MAX) ? TSUP_PER_MAX : code;
    return TSUP_BASE_CYCLES << c;
  endfunction

  function automatic tsup_mode_e tsup_mode(
    input logic fuse,
    input logic reset_enable_bit,
    input logic timeout_irq_enable
  );
    tsup_mode_e m;
    if (fuse) begin
      m = TSUP_RESET;
    end else begin
      unique case ({reset_enable_bit, timeout_irq_enable})
        2'b00: m = TSUP_STOPPED;
        2'b01: m = TSUP_IRQ;
        2'b10: m = TSUP_RESET;
        2'b11: m = TSUP_IRQ_RESET;
      endcase
    end
    return m;
  endfunction

endpackage

// file: rtl/tsup_sync.sv
`timescale 1ns/1ns
module tsup_sync
  import tsup_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// file: rtl/tsup_apb.sv
`timescale 1ns/1ns
module tsup_apb
  import tsup_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [TSUP_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [7:0] ctrl_rd_in,
  input wire logic [TSUP_CNT_W-1:0] count_rd_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output tsup_wr_s wr_out
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic hit_ctrl;
  logic hit_count;
  logic [31:0] prdata_q;

  assign hit_ctrl = (paddr_in == TSUP_ADDR_CTRL);
  assign hit_count = (paddr_in == TSUP_ADDR_COUNT);

  // zero wait states keeps the unlock window reachable in time
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~(hit_ctrl | hit_count);

  // write takes effect at the access edge only
  assign wr_out.wr = psel_in & penable_in & pwrite_in & hit_ctrl;
  assign wr_out.data = tsup_ctrl_s'(pwdata_in[7:0]);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prdata_q <= 32'h00000000;
    end else if (psel_in && !penable_in) begin
      if (hit_ctrl) begin
        prdata_q <= {24'h000000, ctrl_rd_in};
      end else if (hit_count) begin
        prdata_q <= {11'h000, count_rd_in};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  assign prdata_out = prdata_q;

endmodule

// file: sim/tsup_top_sva.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module tsup_top_sva
  import tsup_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [TSUP_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic always_on_fuse_in,
  input wire logic restart_in,
  input wire logic irq_ack_in,
  input wire logic global_irq_en_in,
  input wire logic timeout_reset_flag_in,
  input wire logic irq_req_out,
  input wire logic wake_out,
  input wire logic reset_req_out
);
  logic acc, rd0, mapped;
  logic [2:0] fuse_q, hold_q;
  assign acc = psel_in && penable_in;
  assign rd0 = acc && !pwrite_in && paddr_in == TSUP_ADDR_CTRL;
  assign mapped = paddr_in == TSUP_ADDR_CTRL || paddr_in == TSUP_ADDR_COUNT;
  // saturating counts: forced reads are judged only once synchronisers settle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !always_on_fuse_in) begin
      fuse_q <= 3'h0;
    end else if (fuse_q != 3'h7) begin
      fuse_q <= fuse_q + 3'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !(always_on_fuse_in || timeout_reset_flag_in)) begin
      hold_q <= 3'h0;
    end else if (hold_q != 3'h7) begin
      hold_q <= hold_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_unlock;
    acc && pwrite_in && paddr_in == TSUP_ADDR_CTRL && pwdata_in[4] &&
      pwdata_in[3];
  endsequence
  sequence s_late_rd;
    (!psel_in)[*6] ##1 (psel_in && !penable_in) ##1 rd0;
  endsequence
  AST_UNLOCK_CLOSE: assert property (s_unlock ##1 s_late_rd |->
    !prdata_out[TSUP_BIT_UNLOCK]) else $error("unlock window left open");
  AST_SLVERR: assert property (acc |-> pslverr_out == !mapped)
    else $error("error response wrong for address");
  AST_IRQ_REQ: assert property (irq_req_out ==
    (wake_out && $past(global_irq_en_in))) else $error("irq request wrong");
  AST_RST_PULSE: assert property (reset_req_out |=> !reset_req_out)
    else $error("reset request longer than one cycle");
  AST_RESTART: assert property (restart_in |-> ##2 (!reset_req_out)[*8])
    else $error("reset request right after restart");
  AST_FORCE_WDE: assert property (rd0 && hold_q == 3'h7 |->
    prdata_out[TSUP_BIT_WDE]) else $error("reset enable not forced");
  AST_FUSE_IE: assert property (rd0 && fuse_q == 3'h7 |->
    !prdata_out[TSUP_BIT_IE]) else $error("irq enable not locked off");
  AST_ACK: assert property (irq_ack_in |-> ##2 !wake_out)
    else $error("flag survived vector execution");
endmodule
bind tsup_top tsup_top_sva u_sva (.clk_in, .reset_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .pslverr_out, .always_on_fuse_in, .restart_in, .irq_ack_in,
  .global_irq_en_in, .timeout_reset_flag_in, .irq_req_out, .wake_out,
  .reset_req_out);

// file: sim/tsup_top_bench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module tsup_top_bench
  import tsup_pkg::*;
();
  // oscillator tick every 4 clocks keeps code 0 near 8192 clocks
  localparam int OSC_DIV = 4;
  localparam int PER0 = OSC_DIV * 2048;
  logic clk_in, reset_n_in, psel_in, penable_in, pwrite_in, err_q;
  logic [TSUP_ADDR_W-1:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_q;
  logic pready_out, pslverr_out, osc_128k_in, always_on_fuse_in;
  logic restart_in, irq_ack_in, global_irq_en_in, timeout_reset_flag_in;
  logic irq_req_out, wake_out, reset_req_out;
  logic [1:0] div_q;
  int mismatches, samples_checked, resets, n;
  tsup_top u_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .osc_128k_in, .always_on_fuse_in, .restart_in, .irq_ack_in,
    .global_irq_en_in, .timeout_reset_flag_in, .irq_req_out, .wake_out,
    .reset_req_out);
  assign osc_128k_in = div_q[1];
  always @(posedge clk_in) begin
    div_q <= div_q + 2'h1;
    if (reset_req_out === 1'b1) resets <= resets + 1;
  end
  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd_q = prdata_out;
    err_q = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr8(input logic [7:0] v);
    apb(1'b1, TSUP_ADDR_CTRL, {24'h000000, v});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd_q, exp);
  endtask
  // a wait that runs out is a mismatch, so a hang never passes
  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 3 * PER0) begin
      @(posedge clk_in);
      n++;
    end
    if (s !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
    end
  endtask
  task automatic t_regs();
    rd(TSUP_ADDR_CTRL, 32'h00000000);
    rd(TSUP_ADDR_COUNT, 32'h00000000);
    apb(1'b0, 12'h008, 32'h00000000);
    check(err_q, 1'b1);
  endtask
  task automatic t_unlock();
    wr8(8'h08);
    rd(TSUP_ADDR_CTRL, 32'h00000008);
    wr8(8'h10);
    wr8(8'h00);
    rd(TSUP_ADDR_CTRL, 32'h00000008);
    restart_in <= 1'b1;
    @(posedge clk_in);
    restart_in <= 1'b0;
    wr8(8'h18);
    wr8(8'h01);
    rd(TSUP_ADDR_CTRL, 32'h00000001);
    wr8(8'h18);
    repeat (5) @(posedge clk_in);
    rd(TSUP_ADDR_CTRL, 32'h00000009);
    wr8(8'h00);
    rd(TSUP_ADDR_CTRL, 32'h00000009);
    wr8(8'h18);
    wr8(8'h00);
    rd(TSUP_ADDR_CTRL, 32'h00000000);
  endtask
  task automatic t_irq();
    wr8(8'h40);
    repeat (3) begin
      repeat (PER0 / 2) @(posedge clk_in);
      restart_in <= 1'b1;
      @(posedge clk_in);
      restart_in <= 1'b0;
    end
    check(wake_out, 1'b0);
    apb(1'b0, TSUP_ADDR_COUNT, 32'h00000000);
    check(rd_q < 4, 1'b1);
    wait_hi(irq_req_out);
    check(n > PER0 - 24 && n < PER0 + 16, 1'b1);
    rd(TSUP_ADDR_CTRL, 32'h000000C0);
    global_irq_en_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({irq_req_out, wake_out}, 2'h1);
    global_irq_en_in <= 1'b1;
    wr8(8'hC0);
    rd(TSUP_ADDR_CTRL, 32'h00000040);
    wr8(8'h00);
  endtask
  task automatic t_combined();
    wr8(8'h48);
    wait_hi(wake_out);
    rd(TSUP_ADDR_CTRL, 32'h000000C8);
    check(resets, 0);
    irq_ack_in <= 1'b1;
    @(posedge clk_in);
    irq_ack_in <= 1'b0;
    rd(TSUP_ADDR_CTRL, 32'h00000008);
    wait_hi(reset_req_out);
    @(posedge clk_in);
    check(resets, 1);
    rd(TSUP_ADDR_CTRL, 32'h00000008);
    wr8(8'h48);
    wait_hi(wake_out);
    wait_hi(reset_req_out);
    @(posedge clk_in);
    check(resets, 2);
    rd(TSUP_ADDR_CTRL, 32'h000000C8);
    irq_ack_in <= 1'b1;
    @(posedge clk_in);
    irq_ack_in <= 1'b0;
  endtask
  task automatic t_force();
    timeout_reset_flag_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    wr8(8'h18);
    wr8(8'h00);
    rd(TSUP_ADDR_CTRL, 32'h00000008);
    timeout_reset_flag_in <= 1'b0;
    @(posedge clk_in);
    wr8(8'h18);
    wr8(8'h00);
    rd(TSUP_ADDR_CTRL, 32'h00000000);
    always_on_fuse_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    wr8(8'h40);
    rd(TSUP_ADDR_CTRL, 32'h00000008);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end
  initial begin
    {reset_n_in, psel_in, penable_in, pwrite_in, restart_in} = 5'h00;
    {irq_ack_in, always_on_fuse_in, timeout_reset_flag_in} = 3'h0;
    global_irq_en_in = 1'b1;
    paddr_in = 12'h000;
    pwdata_in = 32'h00000000;
    div_q = 2'h0;
    {mismatches, samples_checked, resets} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_unlock();
    t_irq();
    t_combined();
    t_force();
    stop_test();
  end
endmodule
